// ---- hdl/lmceoc_top.sv ----
// Maintenance channel access and operations command handling, AHB-Lite slave.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
// ============================================================================
module lmceoc_top (
  // Clock and reset
  input  logic                      I_CLK,
  input  logic                      I_RESETN,
  // AHB-Lite slave
  input  logic                      I_HSEL,
  input  logic [31:0]               I_HADDR,
  input  logic [1:0]                I_HTRANS,
  input  logic                      I_HWRITE,
  input  logic [2:0]                I_HSIZE,
  input  logic [31:0]               I_HWDATA,
  input  logic                      I_HREADY,
  output logic [31:0]               O_HRDATA,
  output logic                      O_HREADYOUT,
  output logic                      O_HRESP,
  // Line state and transmit framer timing
  input  lmceoc_pkg::lmceoc_state_t I_LINE_STATE,
  input  logic                      I_SF_TX_ON,
  input  logic                      I_MBITS_TRANSP,
  input  logic                      I_BF_START,
  input  logic [2:0]                I_BF_IDX,
  input  logic [11:0]               I_CRC_TX,
  output logic [5:0]                O_M_TX,
  // Receive deframer
  input  logic                      I_M_RX_VALID,
  input  logic [2:0]                I_M_RX_IDX,
  input  logic [5:0]                I_M_RX,
  // Commands in effect
  output logic                      O_LOOP_COMPLETE,
  output logic                      O_LOOP_B1,
  output logic                      O_LOOP_B2,
  output logic                      O_LOOP_SIDE,
  output logic                      O_CRC_INVERT,
  output logic                      O_FEBE_STOP,
  output logic                      O_NEBE_STOP,
  output logic                      O_LOOP_REQUEST
);

  // ==========================================================================
  // Storage
  logic [0:0]              ctrl_ff;
  logic [11:0]             ops_tx_ff;
  logic [7:0]              m4_tx_ff;
  logic [3:0]              m56_tx_ff;
  logic [4:0]              istat_ff;
  lmceoc_pkg::lmceoc_cmd_t cmd_ff;
  logic                    wr_pend_ff;
  logic [7:0]              waddr_ff;
  logic [31:0]             hrdata_ff;
  logic                    hready_ff;
  logic [11:0]             eoc_sh_ff;
  logic [7:0]              m4_sh_ff;
  logic [3:0]              m56_sh_ff;
  logic [5:0]              m_tx_ff;
  logic                    rx_en_ff;
  logic [8:0]              eoc_acc_ff;
  logic [6:0]              m4_acc_ff;
  logic [1:0]              m56_acc_ff;
  logic                    rx_en;
  logic [11:0]             ops_rx;
  logic [7:0]              m4_rx;
  logic [3:0]              m56_rx;
  logic                    ops_chg;
  logic                    m4_chg;
  logic                    m56_chg;

  // ==========================================================================
  // Bus slave decode
  // Only whole words are supported; byte lanes and upper address bits are
  // not decoded, so narrower writes still update the whole register.
  wire        addr_ph     = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire        rd_ph       = addr_ph & ~I_HWRITE;
  wire        nxt_wr_pend = addr_ph & I_HWRITE;
  wire [7:0]  nxt_waddr   = addr_ph ? I_HADDR[7:0] : waddr_ff;
  wire [7:0]  ra          = I_HADDR[7:0];

  wire        wr_ctrl  = wr_pend_ff & (waddr_ff == lmceoc_pkg::OFS_CTRL);
  wire        wr_ops   = wr_pend_ff & (waddr_ff == lmceoc_pkg::OFS_OPS_TX);
  wire        wr_m4    = wr_pend_ff & (waddr_ff == lmceoc_pkg::OFS_M4_TX);
  wire        wr_m56   = wr_pend_ff & (waddr_ff == lmceoc_pkg::OFS_M56_TX);
  wire        wr_istat = wr_pend_ff & (waddr_ff == lmceoc_pkg::OFS_ISTAT);
  wire        wr_loop  = wr_pend_ff & (waddr_ff == lmceoc_pkg::OFS_LOOP);

  wire [31:0] rd_data =
    (ra == lmceoc_pkg::OFS_CTRL)   ? {31'h0, ctrl_ff}   :
    (ra == lmceoc_pkg::OFS_OPS_TX) ? {20'h0, ops_tx_ff} :
    (ra == lmceoc_pkg::OFS_M4_TX)  ? {24'h0, m4_tx_ff}  :
    (ra == lmceoc_pkg::OFS_M56_TX) ? {28'h0, m56_tx_ff} :
    (ra == lmceoc_pkg::OFS_OPS_RX) ? {20'h0, ops_rx}    :
    (ra == lmceoc_pkg::OFS_M4_RX)  ? {24'h0, m4_rx}     :
    (ra == lmceoc_pkg::OFS_M56_RX) ? {28'h0, m56_rx}    :
    (ra == lmceoc_pkg::OFS_ISTAT)  ? {27'h0, istat_ff}  :
    (ra == lmceoc_pkg::OFS_LOOP)   ? {24'h0, cmd_ff}    : 32'h0;
  wire [31:0] nxt_hrdata = rd_ph ? rd_data : 32'h0;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 8'h00;
      hrdata_ff  <= 32'h0;
      hready_ff  <= 1'b1;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      waddr_ff   <= nxt_waddr;
      hrdata_ff  <= nxt_hrdata;
      hready_ff  <= 1'b1;
    end
  end

  assign O_HRDATA    = hrdata_ff;
  assign O_HREADYOUT = hready_ff;
  assign O_HRESP     = 1'b0;

  // ==========================================================================
  // Receive path
  always_comb begin
    case (I_LINE_STATE)
      lmceoc_pkg::LS_SYNC1,
      lmceoc_pkg::LS_SYNC2,
      lmceoc_pkg::LS_WAIT_ACT,
      lmceoc_pkg::LS_TRANSP,
      lmceoc_pkg::LS_ERR_ST,
      lmceoc_pkg::LS_PEND_ST,
      lmceoc_pkg::LS_PEND_U,
      lmceoc_pkg::LS_ALOOP: rx_en = 1'b1;
      default:              rx_en = 1'b0;
    endcase
  end

  // The preset cycle drops any word in flight so stale bits never report.
  wire       rx_entry  = rx_en & ~rx_en_ff;
  wire       rxv       = I_M_RX_VALID & rx_en & ~rx_entry;
  wire [1:0] rk        = I_M_RX_IDX[1:0];
  wire [11:0] eoc_word = {eoc_acc_ff, I_M_RX[5:3]};
  wire [7:0]  m4_word  = {m4_acc_ff, I_M_RX[2]};
  wire [3:0]  m56_word = {m56_acc_ff, I_M_RX[1:0]};
  wire        eoc_done = rxv & (rk == lmceoc_pkg::OPS_LAST_K);
  wire        m4_done  = rxv & (I_M_RX_IDX == lmceoc_pkg::BF_LAST);
  wire        m56_done = rxv & (I_M_RX_IDX == lmceoc_pkg::BF_M56_LAST);
  wire        m56_take = rxv & (I_M_RX_IDX == lmceoc_pkg::BF_FIRST);

  wire [8:0] nxt_eoc_acc = rx_entry ? 9'h1FF :
                           rxv ? {eoc_acc_ff[5:0], I_M_RX[5:3]} : eoc_acc_ff;
  wire [6:0] nxt_m4_acc  = rx_entry ? 7'h7F :
                           rxv ? {m4_acc_ff[5:0], I_M_RX[2]} : m4_acc_ff;
  wire [1:0] nxt_m56_acc = rx_entry ? 2'h3 :
                           m56_take ? I_M_RX[1:0] : m56_acc_ff;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rx_en_ff   <= 1'b0;
      eoc_acc_ff <= 9'h1FF;
      m4_acc_ff  <= 7'h7F;
      m56_acc_ff <= 2'h3;
    end else begin
      rx_en_ff   <= rx_en;
      eoc_acc_ff <= nxt_eoc_acc;
      m4_acc_ff  <= nxt_m4_acc;
      m56_acc_ff <= nxt_m56_acc;
    end
  end

  lmceoc_rx_cap #(.W(12), .RST(lmceoc_pkg::OPS_RX_RST)) u_ops_rx (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_preset  (rx_entry),
    .i_load    (eoc_done),
    .i_value   (eoc_word),
    .o_value   (ops_rx),
    .o_changed (ops_chg)
  );

  lmceoc_rx_cap #(.W(8), .RST(lmceoc_pkg::M4_RX_RST)) u_m4_rx (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_preset  (rx_entry),
    .i_load    (m4_done),
    .i_value   (m4_word),
    .o_value   (m4_rx),
    .o_changed (m4_chg)
  );

  lmceoc_rx_cap #(.W(4), .RST(lmceoc_pkg::M56_RX_RST)) u_m56_rx (
    .i_clk     (I_CLK),
    .i_resetn  (I_RESETN),
    .i_preset  (rx_entry),
    .i_load    (m56_done),
    .i_value   (m56_word),
    .o_value   (m56_rx),
    .o_changed (m56_chg)
  );

  // ==========================================================================
  // Command interpreter, active only in auto mode
  wire [2:0] c_addr = eoc_word[11:9];
  wire       c_msg  = eoc_word[8];
  wire [7:0] c_info = eoc_word[7:0];
  wire       addr_ok = (c_addr == lmceoc_pkg::ADDR_NT) |
                       (c_addr == lmceoc_pkg::ADDR_BCAST);
  wire is_loop = c_info == lmceoc_pkg::CODE_LOOP;
  wire is_lb1  = c_info == lmceoc_pkg::CODE_LB1;
  wire is_lb2  = c_info == lmceoc_pkg::CODE_LB2;
  wire is_rcrc = c_info == lmceoc_pkg::CODE_RCRC;
  wire is_ncrc = c_info == lmceoc_pkg::CODE_NCRC;
  wire is_rtn  = c_info == lmceoc_pkg::CODE_RTN;
  wire is_hold = c_info == lmceoc_pkg::CODE_HOLD;
  wire defined = is_loop | is_lb1 | is_lb2 | is_rcrc | is_ncrc | is_rtn | is_hold;

  wire        reply_go = ctrl_ff[0] & eoc_done;
  wire [11:0] reply =
    !addr_ok            ? lmceoc_pkg::HOLD_REPLY :
    (!c_msg | !defined) ? {c_addr, 1'b1, lmceoc_pkg::CODE_UTC} :
                          eoc_word;
  // Hold is defined but acts on nothing, so it only gets echoed.
  wire exec = reply_go & addr_ok & c_msg & defined;
  wire return_normal_command  = exec & is_rtn;

  lmceoc_pkg::lmceoc_cmd_t cmd_set;
  assign cmd_set.complete  = exec & is_loop;
  assign cmd_set.loop_req  = exec & is_loop;
  assign cmd_set.b1        = exec & is_lb1;
  assign cmd_set.b2        = exec & is_lb2;
  assign cmd_set.side      = exec & (is_lb1 | is_lb2);
  assign cmd_set.crc_inv   = exec & is_rcrc;
  assign cmd_set.febe_stop = exec & is_rcrc;
  assign cmd_set.nebe_stop = exec & is_ncrc;

  // Commands latch and run side by side until released.
  wire [7:0] cmd_base = wr_loop ? I_HWDATA[7:0] : cmd_ff;
  wire [7:0] nxt_cmd  = return_normal_command ? lmceoc_pkg::CMD_RST : (cmd_base | cmd_set);

  // ==========================================================================
  // Software registers and event flags
  wire       tick6  = I_BF_START & (I_BF_IDX[1:0] == lmceoc_pkg::OPS_FIRST_K);
  wire       tick12 = I_BF_START & (I_BF_IDX == lmceoc_pkg::BF_FIRST);
  wire [4:0] st_set;
  assign st_set[lmceoc_pkg::ST_6MS]  = tick6;
  assign st_set[lmceoc_pkg::ST_12MS] = tick12;
  assign st_set[lmceoc_pkg::ST_OPS]  = ops_chg;
  assign st_set[lmceoc_pkg::ST_M4]   = m4_chg;
  assign st_set[lmceoc_pkg::ST_M56]  = m56_chg;
  // A flag raised in the clearing cycle survives the clear.
  wire [4:0] st_clr    = wr_istat ? I_HWDATA[4:0] : 5'h00;
  wire [4:0] nxt_istat = (istat_ff & ~st_clr) | st_set;

  // An automatic reply overrides a software write in the same cycle.
  wire [11:0] nxt_ops_tx = return_normal_command ? lmceoc_pkg::OPS_TX_RST :
                           reply_go ? reply :
                           wr_ops ? I_HWDATA[11:0] : ops_tx_ff;
  wire [7:0]  nxt_m4_tx  = wr_m4 ? I_HWDATA[7:0] : m4_tx_ff;
  wire [3:0]  nxt_m56_tx = wr_m56 ? I_HWDATA[3:0] : m56_tx_ff;
  wire [0:0]  nxt_ctrl   = wr_ctrl ? I_HWDATA[0:0] : ctrl_ff;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_ff   <= lmceoc_pkg::CTRL_RST;
      ops_tx_ff <= lmceoc_pkg::OPS_TX_RST;
      m4_tx_ff  <= lmceoc_pkg::M4_TX_RST;
      m56_tx_ff <= lmceoc_pkg::M56_TX_RST;
      istat_ff  <= lmceoc_pkg::ISTAT_RST;
      cmd_ff    <= lmceoc_pkg::CMD_RST;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      ops_tx_ff <= nxt_ops_tx;
      m4_tx_ff  <= nxt_m4_tx;
      m56_tx_ff <= nxt_m56_tx;
      istat_ff  <= nxt_istat;
      cmd_ff    <= nxt_cmd;
    end
  end

  assign O_LOOP_COMPLETE = cmd_ff.complete;
  assign O_LOOP_B1       = cmd_ff.b1;
  assign O_LOOP_B2       = cmd_ff.b2;
  assign O_LOOP_SIDE     = cmd_ff.side;
  assign O_CRC_INVERT    = cmd_ff.crc_inv;
  assign O_FEBE_STOP     = cmd_ff.febe_stop;
  assign O_NEBE_STOP     = cmd_ff.nebe_stop;
  assign O_LOOP_REQUEST  = cmd_ff.loop_req;

  // ==========================================================================
  // Transmit path
  // Shadows decouple software writes from the bits already on the line: the
  // ops word is taken every half superframe, M4/M56 once per superframe.
  wire        tx_on     = I_SF_TX_ON & I_MBITS_TRANSP;
  wire [11:0] nxt_eoc_sh = tick6 ? ops_tx_ff : eoc_sh_ff;
  wire [7:0]  nxt_m4_sh  = tick12 ? m4_tx_ff : m4_sh_ff;
  wire [3:0]  nxt_m56_sh = tick12 ? m56_tx_ff : m56_sh_ff;

  wire [1:0] tk      = I_BF_IDX[1:0];
  wire [3:0] eoc_lo  = lmceoc_pkg::OPS_TOP_LO - ({2'b00, tk} + {1'b0, tk, 1'b0});
  wire [3:0] crc_lo  = lmceoc_pkg::CRC_TOP_LO - {I_BF_IDX, 1'b0};
  wire [11:0] eoc_shift = nxt_eoc_sh >> eoc_lo;
  wire [11:0] crc_shift = I_CRC_TX >> crc_lo;
  wire [2:0] m1_3    = eoc_shift[2:0];
  wire       m4_bit  = nxt_m4_sh[3'h7 - I_BF_IDX];
  wire [1:0] crc_pair = crc_shift[1:0] ^ {2{cmd_ff.crc_inv}};
  wire [1:0] m56_bits =
    (I_BF_IDX == lmceoc_pkg::BF_FIRST)    ? nxt_m56_sh[3:2] :
    (I_BF_IDX == lmceoc_pkg::BF_M56_LAST) ? nxt_m56_sh[1:0] : crc_pair;
  wire [5:0] nxt_m_tx = !tx_on     ? lmceoc_pkg::MTX_IDLE :
                        I_BF_START ? {m1_3, m4_bit, m56_bits} : m_tx_ff;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      eoc_sh_ff <= lmceoc_pkg::OPS_TX_RST;
      m4_sh_ff  <= lmceoc_pkg::M4_TX_RST;
      m56_sh_ff <= lmceoc_pkg::M56_TX_RST;
      m_tx_ff   <= lmceoc_pkg::MTX_IDLE;
    end else begin
      eoc_sh_ff <= nxt_eoc_sh;
      m4_sh_ff  <= nxt_m4_sh;
      m56_sh_ff <= nxt_m56_sh;
      m_tx_ff   <= nxt_m_tx;
    end
  end

  assign O_M_TX = m_tx_ff;

endmodule : lmceoc_top

// ---- hdl/lmceoc_pkg.sv ----
// Shared constants and types for the maintenance channel and operations command block.
package lmceoc_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AHB-Lite port
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_OPS_TX = 8'h04;
  localparam logic [7:0] OFS_M4_TX  = 8'h08;
  localparam logic [7:0] OFS_M56_TX = 8'h0C;
  localparam logic [7:0] OFS_OPS_RX = 8'h10;
  localparam logic [7:0] OFS_M4_RX  = 8'h14;
  localparam logic [7:0] OFS_M56_RX = 8'h18;
  localparam logic [7:0] OFS_ISTAT  = 8'h1C;
  localparam logic [7:0] OFS_LOOP   = 8'h20;

  // ==========================================================================
  // Values after reset
  localparam logic [0:0]  CTRL_RST   = 1'h0;
  localparam logic [11:0] OPS_TX_RST = 12'h1FF;
  localparam logic [7:0]  M4_TX_RST  = 8'hFF;
  localparam logic [3:0]  M56_TX_RST = 4'hF;
  localparam logic [11:0] OPS_RX_RST = 12'hFFF;
  localparam logic [7:0]  M4_RX_RST  = 8'hFF;
  localparam logic [3:0]  M56_RX_RST = 4'hF;
  localparam logic [4:0]  ISTAT_RST  = 5'h00;
  localparam logic [5:0]  MTX_IDLE   = 6'h3F;

  // ==========================================================================
  // Status bit positions
  localparam int ST_6MS  = 0;
  localparam int ST_12MS = 1;
  localparam int ST_OPS  = 2;
  localparam int ST_M4   = 3;
  localparam int ST_M56  = 4;

  // ==========================================================================
  // Command word fields and codes
  localparam logic [2:0]  ADDR_NT    = 3'h0;
  localparam logic [2:0]  ADDR_BCAST = 3'h7;
  localparam logic [7:0]  CODE_HOLD  = 8'h00;
  localparam logic [7:0]  CODE_LOOP  = 8'h50;
  localparam logic [7:0]  CODE_LB1   = 8'h51;
  localparam logic [7:0]  CODE_LB2   = 8'h52;
  localparam logic [7:0]  CODE_RCRC  = 8'h53;
  localparam logic [7:0]  CODE_NCRC  = 8'h54;
  localparam logic [7:0]  CODE_UTC   = 8'hAA;
  localparam logic [7:0]  CODE_RTN   = 8'hFF;
  localparam logic [11:0] HOLD_REPLY = 12'h100;

  // ==========================================================================
  // Basic frame positions inside a superframe, counted from zero
  localparam logic [2:0] BF_FIRST    = 3'h0;
  localparam logic [2:0] BF_LAST     = 3'h7;
  localparam logic [2:0] BF_M56_LAST = 3'h1;
  localparam logic [1:0] OPS_FIRST_K = 2'h0;
  localparam logic [1:0] OPS_LAST_K  = 2'h3;
  localparam logic [3:0] OPS_TOP_LO  = 4'h9;
  localparam logic [3:0] CRC_TOP_LO  = 4'hE;

  // ==========================================================================
  // Line state as reported by the activation state machine
  typedef enum logic [3:0] {
    LS_RESET    = 4'h0,
    LS_SYNC1    = 4'h1,
    LS_SYNC2    = 4'h2,
    LS_WAIT_ACT = 4'h3,
    LS_TRANSP   = 4'h4,
    LS_ERR_ST   = 4'h5,
    LS_PEND_ST  = 4'h6,
    LS_PEND_U   = 4'h7,
    LS_ALOOP    = 4'h8,
    LS_DEACT    = 4'h9,
    LS_TEST     = 4'hA
  } lmceoc_state_t;

  // Commands in effect; also the loopback control register layout.
  typedef struct packed {
    logic loop_req;
    logic nebe_stop;
    logic febe_stop;
    logic crc_inv;
    logic side;
    logic b2;
    logic b1;
    logic complete;
  } lmceoc_cmd_t;

  localparam lmceoc_cmd_t CMD_RST = 8'h00;

endpackage : lmceoc_pkg

// ---- hdl/lmceoc_rx_cap.sv ----
// Receive maintenance register that flags a change of its stored value.
`timescale 1ns/1ps

module lmceoc_rx_cap #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset
  input  logic         i_clk,
  input  logic         i_resetn,
  // Load control
  input  logic         i_preset,
  input  logic         i_load,
  input  logic [W-1:0] i_value,
  // Stored value and change pulse
  output logic [W-1:0] o_value,
  output logic         o_changed
);

  logic [W-1:0] val_ff;
  logic         chg_ff;

  // A repeated identical word is not a change, so no periodic report occurs.
  wire          changed = i_load & (i_value != val_ff);
  wire [W-1:0]  nxt_val = i_preset ? RST : (changed ? i_value : val_ff);
  wire          nxt_chg = changed & ~i_preset;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      val_ff <= RST;
      chg_ff <= 1'b0;
    end else begin
      val_ff <= nxt_val;
      chg_ff <= nxt_chg;
    end
  end

  assign o_value   = val_ff;
  assign o_changed = chg_ff;

endmodule : lmceoc_rx_cap

// ---- testbench/lmceoc_checker.sv ----
// Port assertions for the maintenance channel block.
`timescale 1ns/1ps

module lmceoc_checker (
  // Clock, reset and bus
  input wire logic        I_CLK, I_RESETN, I_HSEL, I_HWRITE, I_HREADY, O_HREADYOUT, O_HRESP,
  input wire logic [1:0]  I_HTRANS,
  input wire logic [31:0] O_HRDATA,
  // Framer and commands in effect
  input wire logic        I_SF_TX_ON, I_MBITS_TRANSP, I_BF_START,
  input wire logic [2:0]  I_BF_IDX,
  input wire logic [11:0] I_CRC_TX,
  input wire logic [5:0]  O_M_TX,
  input wire logic        O_LOOP_COMPLETE, O_LOOP_B1, O_LOOP_B2, O_LOOP_SIDE,
  input wire logic        O_CRC_INVERT, O_FEBE_STOP, O_LOOP_REQUEST
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  wire        tx_on  = I_SF_TX_ON & I_MBITS_TRANSP;
  wire        rd_req = I_HSEL & I_HTRANS[1] & !I_HWRITE & I_HREADY;
  wire [11:0] crc_sh = I_CRC_TX >> (4'hE - {I_BF_IDX, 1'h0});
  sequence frame_go;
    I_BF_START && tx_on;
  endsequence
  sequence crc_frame;
    frame_go ##0 (I_BF_IDX >= 3'h2);
  endsequence
  okay_resp_a: assert property (O_HRESP == 1'h0) else $error("no OKAY");
  zero_wait_a: assert property (O_HREADYOUT == 1'h1) else $error("wait state");
  rdata_idle_a: assert property (!rd_req |=> O_HRDATA == 32'h0) else $error("stray data");
  clamp_high_a: assert property (!tx_on |=> O_M_TX == 6'h3F) else $error("not clamped");
  frame_hold_a: assert property (tx_on && !I_BF_START |=> $stable(O_M_TX))
    else $error("bits moved inside a frame");
  crc_pair_a: assert property (crc_frame |=>
    O_M_TX[1:0] == ($past(crc_sh[1:0]) ^ {2{$past(O_CRC_INVERT)}})) else $error("crc bits");
  b1_side_a: assert property ($rose(O_LOOP_B1) |-> O_LOOP_SIDE) else $error("b1 side");
  b2_side_a: assert property ($rose(O_LOOP_B2) |-> O_LOOP_SIDE) else $error("b2 side");
  loop_req_a: assert property ($rose(O_LOOP_COMPLETE) |-> O_LOOP_REQUEST) else $error("req");
  crc_febe_a: assert property ($rose(O_CRC_INVERT) |-> O_FEBE_STOP) else $error("febe");
  release_all_a: assert property ($fell(O_LOOP_COMPLETE) |->
    !(O_LOOP_B1 || O_LOOP_B2 || O_LOOP_SIDE || O_CRC_INVERT)) else $error("not released");
endmodule : lmceoc_checker

bind lmceoc_top lmceoc_checker u_chk (
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_HSEL(I_HSEL), .I_HWRITE(I_HWRITE),
  .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .I_HTRANS(I_HTRANS),
  .O_HRDATA(O_HRDATA), .I_SF_TX_ON(I_SF_TX_ON), .I_MBITS_TRANSP(I_MBITS_TRANSP),
  .I_BF_START(I_BF_START), .I_BF_IDX(I_BF_IDX), .I_CRC_TX(I_CRC_TX), .O_M_TX(O_M_TX),
  .O_LOOP_COMPLETE(O_LOOP_COMPLETE), .O_LOOP_B1(O_LOOP_B1), .O_LOOP_B2(O_LOOP_B2),
  .O_LOOP_SIDE(O_LOOP_SIDE), .O_CRC_INVERT(O_CRC_INVERT), .O_FEBE_STOP(O_FEBE_STOP),
  .O_LOOP_REQUEST(O_LOOP_REQUEST));

// ---- testbench/lmceoc_lt_model.sv ----
// Exchange-side line model: frame timing, downstream bits, upstream capture.
`timescale 1ns/1ps

module lmceoc_lt_model #(
  parameter int FP = 40
) (
  // Clock and reset
  input  wire logic        i_clk, i_resetn,
  // Downstream content and upstream bits
  input  wire logic [11:0] i_word,
  input  wire logic [7:0]  i_m4,
  input  wire logic [3:0]  i_m56,
  input  wire logic [5:0]  i_m_tx,
  // Timing, received bits and captured upstream fields
  output logic             o_bf_start, o_rx_valid,
  output logic [2:0]       o_bf_idx, o_rx_idx,
  output logic [5:0]       o_rx,
  output logic [11:0]      o_tx_word,
  output logic [7:0]       o_tx_m4
);
  int          cnt;
  logic [2:0]  idx;
  logic [11:0] acc;
  wire  [11:0] w_sh = i_word << (3 * idx[1:0]);
  wire  [1:0]  m56  = (idx == 3'h0) ? i_m56[3:2] : (idx == 3'h1) ? i_m56[1:0] : 2'h3;
  wire  [5:0]  bits = {w_sh[11:9], i_m4[3'h7 - idx], m56};
  assign o_bf_start = (cnt == 0);
  assign o_bf_idx   = idx;
  assign o_rx_valid = (cnt == FP / 2);
  assign o_rx_idx   = idx;
  // Between frames the line toggles to its inverse every clock, so stale bits are never mistaken for data.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
      idx <= 3'h0;
      o_rx <= 6'h0;
      acc <= 12'h0;
      o_tx_word <= 12'h0;
      o_tx_m4 <= 8'h0;
    end else begin
      cnt <= (cnt == FP - 1) ? 0 : cnt + 1;
      if (cnt == FP - 1) idx <= idx + 3'h1;
      o_rx <= (cnt == FP / 2 - 1) ? bits : ~o_rx;
      if (cnt == 2) begin
        acc <= {acc[8:0], i_m_tx[5:3]};
        o_tx_m4 <= {o_tx_m4[6:0], i_m_tx[2]};
        if (idx[1:0] == 2'h3) o_tx_word <= {acc[8:0], i_m_tx[5:3]};
      end
    end
  end
endmodule : lmceoc_lt_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the maintenance channel block.
`timescale 1ns/1ps

module tb_top;
  logic        clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, sf_on = 1'h1, transp = 1'h1;
  logic        hready, hresp, bf_start, rx_valid;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  bf_idx, rx_idx;
  logic [5:0]  m_tx, m_rx;
  logic [7:0]  m4 = 8'h3C, loop_q, tx_m4;
  logic [3:0]  m56 = 4'h9;
  logic [11:0] crc = 12'hC35, word = 12'h151, tx_word;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  lmceoc_pkg::lmceoc_state_t lstate = lmceoc_pkg::LS_RESET;
  int          err_total = 0, compares = 0;
  logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24};
  logic [11:0] rv[8] = '{12'h0, 12'h1FF, 12'hFF, 12'hF, 12'hFFF, 12'hFF, 12'hF, 12'h0};
  logic [11:0] cw[10] = '{12'h151, 12'hF52, 12'h150, 12'h153, 12'h154,
                          12'h100, 12'h551, 12'h051, 12'h112, 12'h1FF};
  logic [11:0] ct[10] = '{12'h151, 12'hF52, 12'h150, 12'h153, 12'h154,
                          12'h100, 12'h100, 12'h1AA, 12'h1AA, 12'h1FF};
  logic [7:0]  cl[10] = '{8'h0A, 8'h0E, 8'h8F, 8'hBF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  lmceoc_top dut (
    .I_CLK(clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_LINE_STATE(lstate),
    .I_SF_TX_ON(sf_on), .I_MBITS_TRANSP(transp), .I_BF_START(bf_start), .I_BF_IDX(bf_idx),
    .I_CRC_TX(crc), .O_M_TX(m_tx), .I_M_RX_VALID(rx_valid), .I_M_RX_IDX(rx_idx), .I_M_RX(m_rx),
    .O_LOOP_COMPLETE(loop_q[0]), .O_LOOP_B1(loop_q[1]), .O_LOOP_B2(loop_q[2]),
    .O_LOOP_SIDE(loop_q[3]), .O_CRC_INVERT(loop_q[4]), .O_FEBE_STOP(loop_q[5]),
    .O_NEBE_STOP(loop_q[6]), .O_LOOP_REQUEST(loop_q[7]));

  lmceoc_lt_model #(.FP(40)) lt (
    .i_clk(clk), .i_resetn(rst_n), .i_word(word), .i_m4(m4), .i_m56(m56), .i_m_tx(m_tx),
    .o_bf_start(bf_start), .o_rx_valid(rx_valid), .o_bf_idx(bf_idx), .o_rx_idx(rx_idx),
    .o_rx(m_rx), .o_tx_word(tx_word), .o_tx_m4(tx_m4));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'h1, a, d, x);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'h0, a, 32'h0, x);
    chk(x, e);
  endtask : rchk

  // Resumes a few cycles after the downstream frame k has been delivered.
  task automatic wait_rx(input logic [2:0] k);
    do @(posedge clk); while (!(rx_valid === 1'h1 && rx_idx === k));
    repeat (4) @(posedge clk);
  endtask : wait_rx

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #300000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (ra[i]) rchk(ra[i], {20'h0, rv[i]});
    wr(8'h08, 32'hA5);
    wr(8'h0C, 32'h6);
    wr(8'h04, 32'h5A3);
    wr(8'h24, 32'h1);
    rchk(8'h24, 32'h0);
    lstate <= lmceoc_pkg::LS_SYNC1;
    wait_rx(3'h7);
    wait_rx(3'h7);
    chk({20'h0, tx_word}, 32'h5A3);
    chk({24'h0, tx_m4}, 32'hA5);
    rchk(8'h04, 32'h5A3);
    rchk(8'h10, 32'h151);
    rchk(8'h14, 32'h3C);
    rchk(8'h18, 32'h9);
    rchk(8'h1C, 32'h1F);
    wr(8'h1C, 32'h1F);
    wait_rx(3'h7);
    rchk(8'h1C, 32'h3);
    wait_rx(3'h1);
    wr(8'h1C, 32'h3);
    rchk(8'h1C, 32'h0);
    wait_rx(3'h4);
    rchk(8'h1C, 32'h1);
    rchk(8'h20, 32'h0);
    wr(8'h00, 32'h1);
    wait_rx(3'h7);
    foreach (cw[i]) begin
      word <= cw[i];
      wait_rx(3'h7);
      rchk(8'h04, {20'h0, ct[i]});
      rchk(8'h20, {24'h0, cl[i]});
      chk({24'h0, loop_q}, {24'h0, cl[i]});
    end
    lstate <= lmceoc_pkg::LS_DEACT;
    word <= 12'h153;
    wait_rx(3'h7);
    rchk(8'h10, 32'h1FF);
    lstate <= lmceoc_pkg::LS_SYNC1;
    repeat (2) @(posedge clk);
    rchk(8'h10, 32'hFFF);
    rchk(8'h14, 32'hFF);
    sf_on <= 1'h0;
    repeat (3) @(posedge clk);
    chk({26'h0, m_tx}, 32'h3F);
    sf_on <= 1'h1;
    transp <= 1'h0;
    // Two frame starts must pass, or a held idle value would hide a missing clamp.
    wait_rx(3'h1);
    chk({26'h0, m_tx}, 32'h3F);
    tally_and_finish();
  end
endmodule : tb_top
